// file: pkg/fbmap_defines.vh
`ifndef FBMAP_DEFINES_VH
`define FBMAP_DEFINES_VH

// basic point count and extended point count
`define FBMAP_BASIC_POINTS 24
`define FBMAP_EXT_POINTS 128
// link word width and the number of points held in word 1
`define FBMAP_WORD_W 16
`define FBMAP_WORD1_USED 8
// station address range and occupied station slots
`define FBMAP_ADDR_MAX 6'h3f
`define FBMAP_STATIONS 2'h2
// station type code for a remote device station
`define FBMAP_TYPE_REMOTE_DEV 2'h1
// configuration load time after start, in ns
`define FBMAP_CFG_LOAD_NS 2000
`define FBMAP_CLK_NS 20
// indicator stretch time so short activity is visible, in ns
`define FBMAP_BLINK_NS 50000000

`endif

// file: hw/fbmap_pulse_stretch.v
`timescale 1ns/10ps
`default_nettype none

// holds an indicator on for a fixed time after each activity pulse
module fbmap_pulse_stretch #(
	parameter CNT_W = 22,
	parameter [CNT_W-1:0] HOLD = 22'd2500000
) (
	input wire i_clk_sys,
	input wire i_rstn,
	input wire i_pulse,
	output wire o_led
);

	reg [CNT_W-1:0] cnt_q;
	reg [CNT_W-1:0] cnt_d;

	// retrigger on each pulse; a steady stream keeps the lamp lit
	always @* begin
		cnt_d = cnt_q;
		if (i_pulse) begin
			cnt_d = HOLD;
		end else if (cnt_q != {CNT_W{1'b0}}) begin
			cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_q <= {CNT_W{1'b0}};
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign o_led = (cnt_q != {CNT_W{1'b0}});

endmodule // fbmap_pulse_stretch

`default_nettype wire

// file: hw/fbmap_bit_mapper.v
`timescale 1ns/10ps
`default_nettype none
`include "fbmap_defines.vh"

module fbmap_bit_mapper #(
	parameter POINTS_MAX = `FBMAP_EXT_POINTS,
	parameter BLINK_CYCLES = `FBMAP_BLINK_NS / `FBMAP_CLK_NS
) (
	input wire i_clk_sys,
	input wire i_rstn,
	// base unit side, through the jumper connector
	input wire i_base_reset,
	input wire i_ext_enable,
	input wire [POINTS_MAX-1:0] i_controller_virtual_input,
	output reg [POINTS_MAX-1:0] o_controller_virtual_output,
	// rotary switch
	input wire [5:0] i_station_switch,
	// protocol engine side
	input wire i_link_ok,
	input wire i_link_error,
	input wire i_cycle_strobe,
	input wire [POINTS_MAX-1:0] i_remote_input_words,
	output reg [POINTS_MAX-1:0] o_remote_output_words,
	output reg [5:0] o_station_addr,
	output reg [5:0] o_station_last,
	output reg [1:0] o_station_count,
	output reg [1:0] o_station_type,
	output reg o_link_start,
	// indicators
	output wire o_run_indicator,
	output wire o_send_activity_indicator,
	output wire o_receive_activity_indicator,
	output wire o_link_error_indicator
);

	localparam WW = `FBMAP_WORD_W;
	localparam W1 = `FBMAP_WORD1_USED;
	localparam integer CFG_CYCLES = (`FBMAP_CFG_LOAD_NS + `FBMAP_CLK_NS - 1) / `FBMAP_CLK_NS;
	// load counter is 7 bits wide, so the count is cut to that width on purpose
	localparam [6:0] CFG_LAST = CFG_CYCLES[6:0] - 7'h01;

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_LOAD = 2'h1;
	localparam [1:0] ST_RUN = 2'h2;

	// pin inputs pass two flip-flops before use
	reg [5:0] sw_s1_q, sw_s2_q;
	reg rst_s1_q, rst_s2_q, ext_s1_q, ext_s2_q;

	always @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			sw_s1_q <= 6'h00;
			sw_s2_q <= 6'h00;
			rst_s1_q <= 1'b1;
			rst_s2_q <= 1'b1;
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
		end else begin
			sw_s1_q <= i_station_switch;
			sw_s2_q <= sw_s1_q;
			rst_s1_q <= i_base_reset;
			rst_s2_q <= rst_s1_q;
			ext_s1_q <= i_ext_enable;
			ext_s2_q <= ext_s1_q;
		end
	end

	// next station after ours; wraps within the 6-bit range
	function [5:0] next_station;
		input [5:0] a;
		begin
			next_station = a + 6'h01;
		end
	endfunction

	reg [1:0] state_q, state_d;
	reg [6:0] cnt_q, cnt_d;
	reg ext_q, ext_d;

	// start-up sequence: reset of base unit restarts configuration
	always @* begin
		state_d = state_q;
		cnt_d = cnt_q;
		ext_d = ext_q;
		case (state_q)
			ST_IDLE: begin
				if (!rst_s2_q) begin
					state_d = ST_LOAD;
					cnt_d = 7'h00;
				end
			end
			ST_LOAD: begin
				if (rst_s2_q) begin
					state_d = ST_IDLE;
				end else if (cnt_q == CFG_LAST) begin
					state_d = ST_RUN;
					ext_d = ext_s2_q;
				end else begin
					cnt_d = cnt_q + 7'h01;
				end
			end
			ST_RUN: begin
				if (rst_s2_q) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= ST_IDLE;
			cnt_q <= 7'h00;
			ext_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			ext_q <= ext_d;
		end
	end

	wire running = (state_q == ST_RUN);

	// address is latched at load so a switch turned during operation has no effect
	always @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_station_addr <= 6'h00;
			o_station_last <= 6'h01;
			o_station_count <= 2'h0;
			o_station_type <= 2'h0;
			o_link_start <= 1'b0;
		end else begin
			if (state_q == ST_LOAD && cnt_q == CFG_LAST) begin
				o_station_addr <= sw_s2_q;
				o_station_last <= next_station(sw_s2_q);
			end
			o_station_count <= `FBMAP_STATIONS;
			o_station_type <= `FBMAP_TYPE_REMOTE_DEV;
			o_link_start <= running;
		end
	end

	// data mapping, refreshed on each link cycle; extended points only when enabled
	reg [POINTS_MAX-1:0] to_link, to_base;
	integer k;

	always @* begin
		to_link = {POINTS_MAX{1'b0}};
		to_base = {POINTS_MAX{1'b0}};
		for (k = 0; k < WW; k = k + 1) begin
			to_link[k] = i_controller_virtual_input[k];
			to_base[k] = i_remote_input_words[k];
		end
		for (k = 0; k < W1; k = k + 1) begin
			to_link[WW+k] = i_controller_virtual_input[WW+k];
			to_base[WW+k] = i_remote_input_words[WW+k];
		end
		// bits 8..15 of word 1 stay zero in both directions
		for (k = 2 * WW; k < POINTS_MAX; k = k + 1) begin
			if (ext_q) begin
				to_link[k] = i_controller_virtual_input[k];
				to_base[k] = i_remote_input_words[k];
			end
		end
	end

	// outputs hold zero until running so the master never sees stale data
	always @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_remote_output_words <= {POINTS_MAX{1'b0}};
			o_controller_virtual_output <= {POINTS_MAX{1'b0}};
		end else if (!running) begin
			o_remote_output_words <= {POINTS_MAX{1'b0}};
			o_controller_virtual_output <= {POINTS_MAX{1'b0}};
		end else if (i_cycle_strobe) begin
			o_remote_output_words <= to_link;
			o_controller_virtual_output <= to_base;
		end
	end

	// indicator logic; activity lamps are stretched so single cycles are visible
	wire act = running & i_link_ok & i_cycle_strobe;

	assign o_run_indicator = running & i_link_ok;
	assign o_link_error_indicator = running & i_link_error;

	fbmap_pulse_stretch #(
		.CNT_W(22),
		.HOLD(BLINK_CYCLES[21:0])
	) u_send (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.i_pulse(act),
		.o_led(o_send_activity_indicator)
	);

	fbmap_pulse_stretch #(
		.CNT_W(22),
		.HOLD(BLINK_CYCLES[21:0])
	) u_recv (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.i_pulse(act),
		.o_led(o_receive_activity_indicator)
	);

endmodule // fbmap_bit_mapper

`default_nettype wire

// file: bench/fbmap_props.sv
`timescale 1ns/10ps
`default_nettype none
// watches the mapper's ports; all checks live in the one system clock domain
module fbmap_props (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic i_cycle_strobe,
	input wire logic i_link_ok,
	input wire logic i_link_error,
	input wire logic [127:0] i_controller_virtual_input,
	input wire logic [127:0] i_remote_input_words,
	input wire logic [127:0] o_remote_output_words,
	input wire logic [127:0] o_controller_virtual_output,
	input wire logic [5:0] o_station_addr,
	input wire logic [5:0] o_station_last,
	input wire logic [1:0] o_station_count,
	input wire logic [1:0] o_station_type,
	input wire logic o_link_start,
	input wire logic o_run_indicator,
	input wire logic o_link_error_indicator,
	input wire logic o_send_activity_indicator,
	input wire logic o_receive_activity_indicator
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	// a link cycle offered while the start flag is up
	sequence s_take;
		o_link_start && i_cycle_strobe;
	endsequence
	// start flag lags the running state by a cycle, so it must still be up one cycle later
	sequence s_take_run;
		s_take ##1 o_link_start;
	endsequence
	// same, with the link healthy when the cycle was offered
	sequence s_act_run;
		s_take ##0 i_link_ok ##1 o_link_start;
	endsequence
	AST_TX0: assert property (s_take_run |->
		o_remote_output_words[15:0] == $past(i_controller_virtual_input[15:0])) else $error("tx word0");
	AST_TX1: assert property (s_take_run |->
		o_remote_output_words[23:16] == $past(i_controller_virtual_input[23:16])) else $error("tx word1");
	AST_RX0: assert property (s_take_run |->
		o_controller_virtual_output[15:0] == $past(i_remote_input_words[15:0])) else $error("rx word0");
	AST_RX1: assert property (s_take_run |->
		o_controller_virtual_output[23:16] == $past(i_remote_input_words[23:16])) else $error("rx word1");
	AST_PAD: assert property (o_remote_output_words[31:24] == 8'h00 &&
		o_controller_virtual_output[31:24] == 8'h00) else $error("word1 upper byte set");
	AST_SLOT: assert property (o_link_start |-> o_station_count == 2'h2 &&
		o_station_type == 2'h1 && o_station_last == o_station_addr + 6'h01) else $error("slots");
	// lamps follow the running state, which the start flag shows one cycle later
	AST_RUN: assert property (1'b1 |=>
		$past(o_run_indicator) == (o_link_start && $past(i_link_ok))) else $error("run lamp");
	AST_LERR: assert property (1'b1 |=>
		$past(o_link_error_indicator) == (o_link_start && $past(i_link_error))) else $error("error lamp");
	AST_SEND: assert property (s_act_run |-> o_send_activity_indicator)
		else $error("send lamp");
	AST_RECV: assert property (s_act_run |-> o_receive_activity_indicator)
		else $error("receive lamp");
endmodule // fbmap_props
bind fbmap_bit_mapper fbmap_props i_props (.*);
`default_nettype wire

// file: bench/fbmap_master_model.sv
`timescale 1ns/10ps
`default_nettype none
// link master stand-in; idle words are inverted so a stale sample never matches
module fbmap_master_model (
	input wire logic i_send,
	input wire logic i_fault,
	input wire logic [127:0] i_data,
	output logic o_link_ok,
	output logic o_link_error,
	output logic o_cycle_strobe,
	output logic [127:0] o_words
);
	// link health follows the fault request
	assign o_link_ok = !i_fault;
	assign o_link_error = i_fault;
	assign o_cycle_strobe = i_send;
	assign o_words = i_send ? i_data : ~i_data;
endmodule // fbmap_master_model
`default_nettype wire

// file: bench/test_fbmap_bit_mapper.sv
`timescale 1ns/10ps
`default_nettype none
module test_fbmap_bit_mapper;
	logic clk = 1'b0, rstn = 1'b0, base_rst = 1'b0, ext = 1'b0, send = 1'b0, fault = 1'b0;
	logic [5:0] sw = 6'h3f;
	logic [127:0] vin = '0, mdat = '0, mask = 128'hffffff, words, tx, rx;
	logic [5:0] addr, last;
	logic [1:0] cnt, typ;
	logic ok, err, stb, start, run_led, sd_led, rd_led, err_led;
	int miscompares = 0, n_compared = 0;
	fbmap_master_model i_master (.i_send(send), .i_fault(fault), .i_data(mdat),
		.o_link_ok(ok), .o_link_error(err), .o_cycle_strobe(stb), .o_words(words));
	// blink shortened so lamp timing fits the run; one mapper only
	fbmap_bit_mapper #(.BLINK_CYCLES(8)) i_dut (.i_clk_sys(clk), .i_rstn(rstn),
		.i_base_reset(base_rst), .i_ext_enable(ext), .i_controller_virtual_input(vin),
		.o_controller_virtual_output(rx), .i_station_switch(sw), .i_link_ok(ok),
		.i_link_error(err), .i_cycle_strobe(stb), .i_remote_input_words(words),
		.o_remote_output_words(tx), .o_station_addr(addr), .o_station_last(last),
		.o_station_count(cnt), .o_station_type(typ), .o_link_start(start),
		.o_run_indicator(run_led), .o_send_activity_indicator(sd_led),
		.o_receive_activity_indicator(rd_led), .o_link_error_indicator(err_led));
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// bounded wait for the self start
	task automatic wait_run;
		for (int i = 0; i < 300 && start !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (start !== 1'b1) begin
			miscompares++;
			report_and_stop();
		end
	endtask
	// one link cycle; send stays high so calls may run back to back
	task automatic xfer(input logic [127:0] d);
		vin = d;
		mdat = ~d;
		send = 1'b1;
		@(posedge clk);
		#1;
		chk(tx, d & mask);
		chk(rx, ~d & mask);
	endtask
	task automatic t_start;
		wait_run();
		chk({addr, last, cnt, typ}, {6'h3f, 6'h00, 2'h2, 2'h1});
	endtask
	task automatic t_map;
		xfer('1);
		xfer(128'h00800001);
		xfer(128'h00408000);
		send = 1'b0;
		vin = '0;
		repeat (3) @(posedge clk);
		#1;
		chk(tx, 128'h00408000);
		chk({sd_led, rd_led}, 2'b11);
		repeat (10) @(posedge clk);
		#1;
		chk({sd_led, rd_led}, 2'b00);
	endtask
	task automatic t_lamps;
		fault = 1'b1;
		@(posedge clk);
		#1;
		chk({run_led, err_led}, 2'b01);
		fault = 1'b0;
		@(posedge clk);
		#1;
		chk({run_led, err_led}, 2'b10);
	endtask
	// base unit reset restarts with a new address and extended points
	task automatic t_restart;
		base_rst = 1'b1;
		ext = 1'b1;
		sw = 6'h00;
		repeat (5) @(posedge clk);
		#1;
		chk(tx, '0);
		chk(start, '0);
		base_rst = 1'b0;
		wait_run();
		chk({addr, last}, {6'h00, 6'h01});
		mask = ~128'hff000000;
		xfer('1);
		xfer('0);
		send = 1'b0;
	endtask
	initial begin
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (2) @(posedge clk);
		#1;
		rstn = 1'b1;
		t_start();
		t_map();
		t_lamps();
		t_restart();
		report_and_stop();
	end
endmodule // test_fbmap_bit_mapper
`default_nettype wire
